// ==== design/fpk_pkg.sv ====
`default_nettype none
package fpk_pkg;
    localparam logic [11:0] OFF_ADDR = 12'h000;
    localparam logic [11:0] OFF_DATA = 12'h004;
    localparam logic [11:0] OFF_CMD = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_MODE = 12'h010;
    localparam logic [11:0] OFF_KEYED = 12'h014;
    localparam logic [11:0] OFF_IMMED = 12'h018;

    localparam logic [7:0] CMD_NULL = 8'h00;
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
    localparam logic [7:0] CMD_VERIFY = 8'h04;
    localparam logic [7:0] CMD_ERASE = 8'h05;
    localparam logic [7:0] CMD_MASS = 8'h06;
    localparam logic [7:0] CMD_PROTECT = 8'h0c;

    localparam int ST_DONE_BIT = 0;
    localparam int ST_FAIL_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int READ_PROT_BIT = 31;
    localparam int GROUP_LSB = 11;
    localparam logic [3:0] KEY_EN_CODE = 4'hf;

    localparam int ARRAY_BYTES = 65536;
    localparam int FW_BYTES = 2048;
    localparam logic [15:0] USER_BYTES = 16'(ARRAY_BYTES - FW_BYTES);
    localparam int WORD_AW = 15;
    localparam int PAGE_WORDS = 256;
    localparam int USER_WORDS = (ARRAY_BYTES - FW_BYTES) / 2;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    localparam logic [31:0] KEY_ERASED = 32'hffff_ffff;
    localparam logic [31:0] PROT_OPEN = 32'hffff_ffff;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int KEY_FAIL_LIMIT = 3;
    localparam int BOOT_FILL = 3;

    typedef enum logic [1:0] {
        FOP_READ = 2'b00,
        FOP_PROG = 2'b01,
        FOP_PAGE = 2'b10,
        FOP_MASS = 2'b11
    } fpk_fop_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PROG = 2'b10
    } fpk_state_t;
endpackage : fpk_pkg
`default_nettype wire

// ==== design/fpk_flash_if.sv ====
`default_nettype none
interface fpk_flash_if
    import fpk_pkg::*;
#(
    parameter int AW = WORD_AW
);
    logic req;
    fpk_fop_t op;
    logic [AW-1:0] waddr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    modport ctrl (output req, op, waddr, wdata, input rdata, done);
    modport array (input req, op, waddr, wdata, output rdata, done);
endinterface : fpk_flash_if
`default_nettype wire

// ==== design/fpk_flash_array.sv ====
`default_nettype none
module fpk_flash_array
    import fpk_pkg::*;
#(
    parameter int AW = WORD_AW,
    parameter int PAGE_W = PAGE_WORDS,
    parameter int USER_W = USER_WORDS
) (
    input wire logic pclk,
    input wire logic presetn,
    fpk_flash_if.array fl
);
    localparam int PB = $clog2(PAGE_W);

    // whole 64 KB array; the top 2 KB is never addressed by the controller
    logic [15:0] mem [0:(1<<AW)-1];
    logic sweeping;
    logic [AW-1:0] sw_addr;
    logic [AW-1:0] sw_last;

    // erase sweeps one word per clock: slow, but no wide write port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sweeping <= 1'b0;
            sw_addr <= '0;
            sw_last <= '0;
        end else if (!sweeping && fl.req && fl.op == FOP_PAGE) begin
            sweeping <= 1'b1;
            sw_addr <= {fl.waddr[AW-1:PB], {PB{1'b0}}};
            sw_last <= {fl.waddr[AW-1:PB], {PB{1'b1}}};
        end else if (!sweeping && fl.req && fl.op == FOP_MASS) begin
            sweeping <= 1'b1;
            sw_addr <= '0;
            sw_last <= AW'(USER_W - 1);
        end else if (sweeping) begin
            if (sw_addr == sw_last) begin
                sweeping <= 1'b0;
            end else begin
                sw_addr <= sw_addr + 1'b1;
            end
        end
    end

    // programming only clears bits, so a location must be erased first
    always_ff @(posedge pclk) begin
        if (sweeping) begin
            mem[sw_addr] <= ERASED_WORD;
        end else if (fl.req && fl.op == FOP_PROG) begin
            mem[fl.waddr] <= mem[fl.waddr] & fl.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl.rdata <= '0;
            fl.done <= 1'b0;
        end else begin
            if (fl.req && fl.op == FOP_READ) begin
                fl.rdata <= mem[fl.waddr];
            end
            fl.done <= (fl.req && (fl.op == FOP_READ || fl.op == FOP_PROG))
                || (sweeping && sw_addr == sw_last);
        end
    end
endmodule : fpk_flash_array
`default_nettype wire

// ==== design/fpk_flash_protection_key_unit.sv ====
// Implementation choices: the APB slave port and the register addresses.
`default_nettype none
module fpk_flash_protection_key_unit
    import fpk_pkg::*;
#(
    parameter int FAIL_LIMIT = KEY_FAIL_LIMIT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_select_pin,
    output logic serial_download_mode,
    output logic ext_read_blocked,
    output logic [30:0] ext_write_locked,
    output logic flash_busy
);
    fpk_flash_if #(.AW(WORD_AW)) fl ();

    fpk_flash_array #(
        .AW(WORD_AW),
        .PAGE_W(PAGE_WORDS),
        .USER_W(USER_WORDS)
    ) u_array (
        .pclk(pclk),
        .presetn(presetn),
        .fl(fl)
    );

    logic [15:0] addr_reg;
    logic [15:0] data_reg;
    logic [7:0] cmd_reg;
    logic [7:0] mode_reg;
    logic [31:0] keyed_stage;
    logic [31:0] keyed_active;
    logic [31:0] immediate;
    logic [31:0] key_store;
    logic key_set;
    logic [1:0] fail_cnt;
    logic st_done;
    logic st_fail;
    logic seen_done;
    logic seen_fail;
    fpk_state_t state;
    logic [7:0] cur_cmd;
    logic [31:0] eff_prot;
    logic apb_wr;
    logic stat_clr;
    logic cmd_wr;
    logic key_en;
    logic key_ok;
    logic launch;
    fpk_fop_t launch_op;
    logic cmd_fail_now;
    logic cmd_ok_now;
    logic key_commit;
    logic key_store_now;
    logic key_bad;
    logic fin;
    logic mass_end;
    logic [31:0] rd_mux;

    function automatic logic reg_hit(input logic [11:0] a);
        return a == OFF_ADDR || a == OFF_DATA || a == OFF_CMD || a == OFF_STATUS
            || a == OFF_MODE || a == OFF_KEYED || a == OFF_IMMED;
    endfunction : reg_hit

    function automatic logic user_addr(input logic [15:0] a);
        return a < USER_BYTES;
    endfunction : user_addr

    function automatic logic group_open(input logic [15:0] a, input logic [31:0] p);
        return p[a[15:GROUP_LSB]];
    endfunction : group_open

    // both levels must leave a group open for it to be writable
    assign eff_prot = keyed_active & immediate;
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite && reg_hit(paddr);
    assign stat_clr = psel && penable && !pwrite && paddr == OFF_STATUS;
    assign cmd_wr = apb_wr && paddr == OFF_CMD && state == ST_IDLE;
    assign key_en = mode_reg[7:4] == KEY_EN_CODE;
    assign key_ok = {addr_reg, data_reg} == key_store;
    assign fin = state == ST_RUN && fl.done && cur_cmd != CMD_ERASE_WRITE;
    assign mass_end = fin && (cur_cmd == CMD_MASS || cur_cmd == CMD_PROTECT);
    assign flash_busy = state != ST_IDLE;

    assign fl.req = launch;
    assign fl.op = launch_op;
    assign fl.waddr = addr_reg[15:1];
    assign fl.wdata = data_reg;

    always_comb begin
        launch = 1'b0;
        launch_op = FOP_READ;
        cmd_fail_now = 1'b0;
        cmd_ok_now = 1'b0;
        key_commit = 1'b0;
        key_store_now = 1'b0;
        key_bad = 1'b0;
        if (state == ST_PROG) begin
            launch = 1'b1;
            launch_op = FOP_PROG;
        end else if (cmd_wr) begin
            case (pwdata[7:0])
                CMD_NULL: begin
                end
                CMD_READ, CMD_VERIFY: begin
                    launch = user_addr(addr_reg);
                    cmd_fail_now = !user_addr(addr_reg);
                end
                CMD_WRITE: begin
                    launch = user_addr(addr_reg) && group_open(addr_reg, eff_prot);
                    launch_op = FOP_PROG;
                    cmd_fail_now = !launch;
                end
                CMD_ERASE_WRITE, CMD_ERASE: begin
                    launch = user_addr(addr_reg) && group_open(addr_reg, eff_prot);
                    launch_op = FOP_PAGE;
                    cmd_fail_now = !launch;
                end
                CMD_MASS: begin
                    launch = 1'b1;
                    launch_op = FOP_MASS;
                end
                CMD_PROTECT: begin
                    if (!key_en) begin
                        cmd_fail_now = 1'b1;
                    end else if (!key_set) begin
                        key_store_now = 1'b1;
                        key_commit = 1'b1;
                        cmd_ok_now = 1'b1;
                    end else if (key_ok) begin
                        key_commit = 1'b1;
                        cmd_ok_now = 1'b1;
                    end else begin
                        key_bad = 1'b1;
                        launch = fail_cnt == 2'(FAIL_LIMIT - 1);
                        launch_op = FOP_MASS;
                        cmd_fail_now = !launch;
                    end
                end
                default: begin
                    cmd_fail_now = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cur_cmd <= CMD_NULL;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        state <= ST_RUN;
                        cur_cmd <= pwdata[7:0];
                    end
                end
                ST_RUN: begin
                    if (fl.done) begin
                        state <= (cur_cmd == CMD_ERASE_WRITE) ? ST_PROG : ST_IDLE;
                    end
                end
                ST_PROG: begin
                    state <= ST_RUN;
                    cur_cmd <= CMD_WRITE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // only bits the reader actually saw are cleared; a new set always wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_done <= 1'b0;
            st_fail <= 1'b0;
        end else begin
            if (fin || cmd_ok_now || cmd_fail_now) begin
                st_done <= 1'b1;
            end else if (stat_clr && seen_done) begin
                st_done <= 1'b0;
            end
            if (cmd_fail_now || (fin && cur_cmd == CMD_VERIFY && fl.rdata != data_reg)
                || (fin && cur_cmd == CMD_PROTECT)) begin
                st_fail <= 1'b1;
            end else if (stat_clr && seen_fail) begin
                st_fail <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= '0;
            data_reg <= '0;
            cmd_reg <= CMD_NULL;
            mode_reg <= MODE_RESET;
        end else begin
            if (apb_wr && state == ST_IDLE && paddr == OFF_ADDR) begin
                addr_reg <= pwdata[15:0];
            end
            if (fin && cur_cmd == CMD_READ) begin
                data_reg <= fl.rdata;
            end else if (apb_wr && state == ST_IDLE && paddr == OFF_DATA) begin
                data_reg <= pwdata[15:0];
            end
            if (cmd_wr) begin
                cmd_reg <= pwdata[7:0];
            end
            if (apb_wr && paddr == OFF_MODE) begin
                mode_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            immediate <= PROT_OPEN;
            keyed_stage <= PROT_OPEN;
        end else begin
            if (apb_wr && paddr == OFF_IMMED) begin
                immediate <= pwdata;
            end
            if (apb_wr && paddr == OFF_KEYED) begin
                keyed_stage <= pwdata;
            end
        end
    end

    // keyed value only moves through the protect command or a mass erase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keyed_active <= PROT_OPEN;
            key_store <= KEY_ERASED;
            key_set <= 1'b0;
            fail_cnt <= '0;
        end else if (mass_end) begin
            keyed_active <= PROT_OPEN;
            key_store <= KEY_ERASED;
            key_set <= 1'b0;
            fail_cnt <= '0;
        end else begin
            if (key_store_now) begin
                key_store <= {addr_reg, data_reg};
                key_set <= 1'b1;
            end
            if (key_commit) begin
                keyed_active <= keyed_stage;
                fail_cnt <= '0;
            end else if (key_bad) begin
                fail_cnt <= fail_cnt + 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        case (paddr)
            OFF_ADDR: rd_mux = {16'h0000, addr_reg};
            OFF_DATA: rd_mux = {16'h0000, data_reg};
            OFF_CMD: rd_mux = {24'h000000, cmd_reg};
            OFF_STATUS: rd_mux = {29'h0000000, flash_busy, st_fail, st_done};
            OFF_MODE: rd_mux = {24'h000000, mode_reg};
            OFF_KEYED: rd_mux = keyed_active;
            OFF_IMMED: rd_mux = immediate;
            default: rd_mux = '0;
        endcase
    end

    // read data is captured in the setup cycle so pready can stay high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            seen_done <= 1'b0;
            seen_fail <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= !reg_hit(paddr);
            seen_done <= st_done;
            seen_fail <= st_fail;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_read_blocked <= 1'b0;
            ext_write_locked <= '0;
        end else begin
            ext_read_blocked <= !eff_prot[READ_PROT_BIT];
            ext_write_locked <= ~eff_prot[30:0];
        end
    end

    logic boot_s1;
    logic boot_s2;
    logic boot_s3;
    logic [1:0] boot_cnt;
    logic boot_taken;

    // strap is caught once, after the synchroniser has filled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_s1 <= 1'b1;
            boot_s2 <= 1'b1;
            boot_s3 <= 1'b1;
            boot_cnt <= '0;
            boot_taken <= 1'b0;
            serial_download_mode <= 1'b0;
        end else begin
            boot_s1 <= boot_select_pin;
            boot_s2 <= boot_s1;
            boot_s3 <= boot_s2;
            if (boot_cnt != 2'(BOOT_FILL)) begin
                boot_cnt <= boot_cnt + 1'b1;
            end else if (!boot_taken && boot_s2 == boot_s3) begin
                boot_taken <= 1'b1;
                serial_download_mode <= !boot_s3;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_status_read_clear: assert property (
        stat_clr && seen_done && !fin && !cmd_ok_now && !cmd_fail_now |=> !st_done)
        else $error("done bit not cleared by status read");
    chk_done_on_finish: assert property (fin |=> st_done ##0 !flash_busy)
        else $error("done bit missing after completion");
    chk_read_loads_data: assert property (
        fin && cur_cmd == CMD_READ |=> data_reg == $past(fl.rdata))
        else $error("read did not load data register");
    chk_verify_result: assert property (
        fin && cur_cmd == CMD_VERIFY && fl.rdata != data_reg |=> st_fail)
        else $error("verify mismatch not reported");
    chk_write_guard: assert property (
        fl.req && (fl.op == FOP_PROG || fl.op == FOP_PAGE)
        |-> eff_prot[fl.waddr[14:10]] && fl.waddr < 15'(USER_WORDS))
        else $error("write reached a protected or hidden group");
    chk_key_lockout: assert property (
        key_bad && fail_cnt == 2'(FAIL_LIMIT - 1) |=> flash_busy && cur_cmd == CMD_PROTECT)
        else $error("third bad key did not start mass erase");
    chk_key_restore: assert property (
        mass_end |=> key_store == KEY_ERASED && !key_set && fail_cnt == 2'd0)
        else $error("mass erase did not restore key");
    chk_key_hold: assert property (
        key_bad |=> $stable(keyed_active) || $past(fail_cnt) == 2'(FAIL_LIMIT - 1))
        else $error("keyed protection changed on bad key");
    chk_immediate_write: assert property (
        apb_wr && paddr == OFF_IMMED |=> immediate == $past(pwdata))
        else $error("immediate protection not written");

    cov_key_install: cover property (key_store_now ##1 key_set);
    cov_key_mass: cover property (key_bad && launch ##1 (flash_busy && cur_cmd == CMD_PROTECT));
    cov_verify_pass: cover property (fin && cur_cmd == CMD_VERIFY && fl.rdata == data_reg);
endmodule : fpk_flash_protection_key_unit
`default_nettype wire

// ==== tb/fpk_host_model.sv ====
`default_nettype none
module fpk_host_model
    import fpk_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic timed_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        timed_out = 1'b0;
    end

    // idle edge first: a release never shares a step with the next request
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) timed_out <= 1'b1;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask : rd

    // mass erase runs ~32k cycles, so the poll bound is generous
    task automatic run(input logic [7:0] c, output logic [31:0] st);
        int n;
        wr(OFF_CMD, {24'h0, c});
        st = 32'h0000_0000;
        for (n = 0; n < 20000 && st[ST_DONE_BIT] !== 1'b1; n++) rd(OFF_STATUS, st);
        if (st[ST_DONE_BIT] !== 1'b1) timed_out <= 1'b1;
    endtask : run

    task automatic install(input logic [31:0] prot, input logic [31:0] key,
                           output logic [31:0] st);
        wr(OFF_ADDR, 32'h0000_0800);
        run(CMD_READ, st);
        run(CMD_VERIFY, st);
        wr(OFF_KEYED, prot);
        wr(OFF_MODE, {24'h0, KEY_EN_CODE, 4'h0});
        wr(OFF_ADDR, {16'h0, key[31:16]});
        wr(OFF_DATA, {16'h0, key[15:0]});
        run(CMD_PROTECT, st);
    endtask : install
endmodule : fpk_host_model
`default_nettype wire

// ==== tb/fpk_flash_protection_key_unit_tb_top.sv ====
`default_nettype none
module fpk_flash_protection_key_unit_tb_top
    import fpk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, boot_select_pin;
    logic serial_download_mode, ext_read_blocked, flash_busy, timed_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, st, d, d2, a, key, p1;
    logic [30:0] ext_write_locked;
    logic [4:0] g;
    int failures = 0;
    int n_checks = 0;
    int i;

    always #25 pclk = ~pclk;

    fpk_flash_protection_key_unit i_fpk_flash_protection_key_unit (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .boot_select_pin(boot_select_pin),
        .serial_download_mode(serial_download_mode), .ext_read_blocked(ext_read_blocked),
        .ext_write_locked(ext_write_locked), .flash_busy(flash_busy)
    );

    fpk_host_model i_fpk_host_model (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timed_out(timed_out)
    );

    function automatic logic [31:0] lock_of(input logic [31:0] p);
        return {1'b0, ~p[30:0]};
    endfunction : lock_of

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // a write into a locked group must fail and leave the word alone
    task automatic locked_write();
        i_fpk_host_model.wr(OFF_ADDR, a);
        i_fpk_host_model.wr(OFF_DATA, 32'h0);
        i_fpk_host_model.run(CMD_WRITE, st);
        check(32'(st[ST_FAIL_BIT]), 32'h1);
        i_fpk_host_model.run(CMD_READ, st);
        i_fpk_host_model.rd(OFF_DATA, r);
        check(r & 32'hffff, d & d2);
    endtask : locked_write

    always @(posedge timed_out) begin
        failures++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        boot_select_pin = 1'b0;
        void'($urandom(32'hf6d6));
        g = 5'($urandom_range(30, 0));
        key = $urandom;
        d = {16'h0, 16'($urandom)};
        d2 = {16'h0, 16'($urandom)};
        a = {16'h0, g, 10'($urandom), 1'b0};
        p1 = PROT_OPEN & ~(32'h1 << g);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        check(32'(serial_download_mode), 32'h1);
        check({1'b0, ext_write_locked}, 32'h0);
        i_fpk_host_model.rd(OFF_KEYED, r);
        check(r, PROT_OPEN);
        i_fpk_host_model.xfer(1'b0, 12'h01c, 32'h0, r, st[0]);
        check(32'(st[0]), 32'h1);
        i_fpk_host_model.run(CMD_MASS, st);
        i_fpk_host_model.rd(OFF_STATUS, r);
        check(r & 32'h3, 32'h0);
        i_fpk_host_model.wr(OFF_ADDR, a);
        i_fpk_host_model.run(CMD_READ, st);
        i_fpk_host_model.rd(OFF_DATA, r);
        check(r & 32'hffff, 32'(ERASED_WORD));
        // program only clears bits, so a second program ands in
        for (i = 0; i < 2; i++) begin
            i_fpk_host_model.wr(OFF_DATA, i == 0 ? d : d2);
            i_fpk_host_model.run(CMD_WRITE, st);
        end
        i_fpk_host_model.run(CMD_READ, st);
        i_fpk_host_model.rd(OFF_DATA, r);
        check(r & 32'hffff, d & d2);
        for (i = 0; i < 2; i++) begin
            i_fpk_host_model.wr(OFF_DATA, i == 0 ? ~(d & d2) : d & d2);
            i_fpk_host_model.run(CMD_VERIFY, st);
            check(32'(st[ST_FAIL_BIT]), i == 0 ? 32'h1 : 32'h0);
        end
        // page erase, then erase-write puts the word back
        i_fpk_host_model.wr(OFF_CMD, {24'h0, CMD_ERASE});
        i_fpk_host_model.rd(OFF_STATUS, r);
        check(r & 32'h4, 32'h4);
        check(32'(flash_busy), 32'h1);
        i_fpk_host_model.run(CMD_ERASE, st);
        check(32'(st[ST_FAIL_BIT]), 32'h0);
        i_fpk_host_model.run(CMD_READ, st);
        i_fpk_host_model.rd(OFF_DATA, r);
        check(r & 32'hffff, 32'(ERASED_WORD));
        i_fpk_host_model.wr(OFF_DATA, d & d2);
        i_fpk_host_model.run(CMD_ERASE_WRITE, st);
        i_fpk_host_model.run(CMD_READ, st);
        i_fpk_host_model.rd(OFF_DATA, r);
        check(r & 32'hffff, d & d2);
        check(32'(flash_busy), 32'h0);
        i_fpk_host_model.wr(OFF_ADDR, {16'h0, 5'h1f, 10'($urandom), 1'b0});
        i_fpk_host_model.run(CMD_READ, st);
        check(32'(st[ST_FAIL_BIT]), 32'h1);
        i_fpk_host_model.wr(OFF_IMMED, p1 & 32'h7fff_ffff);
        repeat (3) @(posedge pclk);
        check({1'b0, ext_write_locked}, lock_of(p1));
        check(32'(ext_read_blocked), 32'h1);
        locked_write();
        i_fpk_host_model.wr(OFF_IMMED, PROT_OPEN);
        i_fpk_host_model.wr(OFF_MODE, 32'h0);
        i_fpk_host_model.run(CMD_PROTECT, st);
        check(32'(st[ST_FAIL_BIT]), 32'h1);
        i_fpk_host_model.install(p1, key, st);
        i_fpk_host_model.rd(OFF_KEYED, r);
        check(r, p1);
        check({1'b0, ext_write_locked}, lock_of(p1));
        locked_write();
        for (i = 0; i < 3; i++) begin
            i_fpk_host_model.install(PROT_OPEN, i < 2 ? ~key : key, st);
            i_fpk_host_model.rd(OFF_KEYED, r);
            check(r, i < 2 ? p1 : PROT_OPEN);
        end
        i_fpk_host_model.install(p1, key, st);
        for (i = 0; i < 3; i++) begin
            i_fpk_host_model.install(PROT_OPEN, key ^ 32'h1, st);
            i_fpk_host_model.rd(OFF_KEYED, r);
            check(r, i < 2 ? p1 : PROT_OPEN);
        end
        check(32'(st[ST_FAIL_BIT]), 32'h1);
        i_fpk_host_model.wr(OFF_ADDR, a);
        i_fpk_host_model.run(CMD_READ, st);
        i_fpk_host_model.rd(OFF_DATA, r);
        check(r & 32'hffff, 32'(ERASED_WORD));
        i_fpk_host_model.install(p1, ~key, st);
        i_fpk_host_model.rd(OFF_KEYED, r);
        check(r, p1);
        // second reset with the strap high: no download, keyed level open
        boot_select_pin <= 1'b1;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        check(32'(serial_download_mode), 32'h0);
        i_fpk_host_model.rd(OFF_KEYED, r);
        check(r, PROT_OPEN);
        tally_and_finish();
    end
endmodule : fpk_flash_protection_key_unit_tb_top
`default_nettype wire
